// [usb_endpoint_stream_fifos_regs.vh]
`ifndef USB_ENDPOINT_STREAM_FIFOS_REGS_VH
`define USB_ENDPOINT_STREAM_FIFOS_REGS_VH

// ----------------------------------------
// FIFO geometry
// ----------------------------------------
`define FIFO_DEPTH      64
`define FIFO_AW         6
`define FIFO_CW         7
`define FIFO_NCH        3

// ----------------------------------------
// Address map, byte address paddr[7:0]
// ----------------------------------------
`define REGION_TX       2'h0
`define REGION_RX       2'h1
`define REGION_MISC     2'h2
`define OFS_DATA        2'h0
`define OFS_CMD         2'h1
`define OFS_CTRL        2'h2
`define OFS_STAT        2'h3
`define MISC_WARN       4'h0
`define MISC_ISTAT      4'h1
`define MISC_IMASK      4'h2

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CMD_LAST_BIT    0
`define THR_RESET       7'h08
`define IMASK_RESET     6'h00
`define EV_TX_LSB       0
`define EV_RX_LSB       3

`endif

// [stream_byte_fifo.v]
`timescale 1ns/1ps
`include "usb_endpoint_stream_fifos_regs.vh"

module stream_byte_fifo #(
    parameter DEPTH = `FIFO_DEPTH,
    parameter AW    = `FIFO_AW,
    parameter CW    = `FIFO_CW
) (
    // Clock and reset
    input  wire          pclk,
    input  wire          presetn,
    input  wire          ce,
    // Fill side
    input  wire          wr_en,
    input  wire [7:0]    wr_data,
    // Drain side
    input  wire          rd_en,
    output wire [7:0]    rd_data,
    // Level
    output wire [CW-1:0] count,
    output wire          full,
    output wire          empty
);

    localparam integer  LAST_I   = DEPTH - 1;
    localparam [AW-1:0] LAST_PTR = LAST_I[AW-1:0];
    localparam [CW-1:0] DEPTH_C  = DEPTH[CW-1:0];

    reg [7:0]    mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [CW-1:0] count_reg;
    reg [7:0]    last_reg;

    wire wr_ok;
    wire rd_ok;

    // ----------------------------------------
    // Level tracking
    // ----------------------------------------
    // Equal pointers alone cannot tell empty from full
    assign full    = (count_reg == DEPTH_C);  // see R19
    assign empty   = (count_reg == {CW{1'b0}});  // see R19
    assign count   = count_reg;
    assign wr_ok   = wr_en & ~full;  // see R7
    assign rd_ok   = rd_en & ~empty;  // see R4
    // Empty read repeats the byte taken last
    assign rd_data = empty ? last_reg : mem[rd_ptr_reg];  // see R13

    always @(posedge pclk)
    begin
        if (ce && wr_ok)
        begin
            mem[wr_ptr_reg] <= wr_data;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {CW{1'b0}};
            last_reg   <= 8'h00;
        end
        else if (ce)
        begin
            if (wr_ok)
            begin
                wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;  // see R6
            end
            if (rd_ok)
            begin
                rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;  // see R3
                last_reg   <= mem[rd_ptr_reg];  // see R13
            end
            if (wr_ok && !rd_ok)
            begin
                count_reg <= count_reg + 1'b1;  // see R19
            end
            else if (rd_ok && !wr_ok)
            begin
                count_reg <= count_reg - 1'b1;  // see R19
            end
        end
    end

endmodule

// [usb_endpoint_stream_fifos.v]
// Functional notes
// R1: Transmit FIFOs serve endpoints 1, 3, 5
// R2: Firmware refills transmit FIFO during long packets
// R3: Transmit read pointer steps and wraps
// R4: Transmit read never passes write pointer
// R5: Empty transmit read without last flag underruns
// R6: Transmit write pointer steps and wraps
// R7: Write into full transmit FIFO discarded
// R8: Transmit warning when occupancy at threshold
// R9: Transmit status shows free bytes
// R10: Receive FIFOs serve endpoints 2, 4, 6
// R11: Firmware drains receive FIFO during long packets
// R12: Receive read pointer steps, wraps, never passes
// R13: Empty receive read repeats last byte
// R14: Receive write pointer steps and wraps
// R15: Store into full receive FIFO overruns
// R16: Receive warning when space at threshold
// R17: Receive status shows unread bytes
// R18: Every FIFO holds 64 bytes
// R19: Occupancy count separates empty from full
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "usb_endpoint_stream_fifos_regs.vh"

module usb_endpoint_stream_fifos #(
    parameter DEPTH = `FIFO_DEPTH,  // see R18
    parameter AW    = `FIFO_AW,
    parameter CW    = `FIFO_CW,
    parameter NCH   = `FIFO_NCH
) (
    // Clock, reset, enable
    input  wire             pclk,
    input  wire             presetn,
    input  wire             ce,
    // APB slave
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [7:0]       paddr,
    input  wire [31:0]      pwdata,
    output reg  [31:0]      prdata,
    output reg              pready,
    output reg              pslverr,
    // Endpoint controller, transmit side
    input  wire [NCH-1:0]   ep_tx_rd,
    output reg  [8*NCH-1:0] ep_tx_data,
    output reg  [NCH-1:0]   ep_tx_avail,
    // Endpoint controller, receive side
    input  wire [NCH-1:0]   ep_rx_wr,
    input  wire [8*NCH-1:0] ep_rx_wdata,
    output reg  [NCH-1:0]   ep_rx_space,
    // Interrupt
    output reg              irq
);

    localparam [CW-1:0] DEPTH_C = DEPTH[CW-1:0];

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function mapped;
        input [7:0] a;
        begin
            if (a[1:0] != 2'h0)
            begin
                mapped = 1'b0;
            end
            else if (a[7:6] == `REGION_TX)
            begin
                mapped = (a[5:4] < NCH);
            end
            else if (a[7:6] == `REGION_RX)
            begin
                mapped = (a[5:4] < NCH) && (a[3:2] != `OFS_CMD);
            end
            else if (a[7:6] == `REGION_MISC)
            begin
                mapped = (a[5:2] == `MISC_WARN) || (a[5:2] == `MISC_ISTAT) ||
                         (a[5:2] == `MISC_IMASK);
            end
            else
            begin
                mapped = 1'b0;
            end
        end
    endfunction

    wire       hit;
    wire       access;
    wire       wr_acc;
    wire       rd_acc;
    wire [1:0] region;
    wire [1:0] chan;
    wire [1:0] sub;
    wire [3:0] misc;

    assign hit    = mapped(paddr);
    assign access = psel & penable & pready;
    assign wr_acc = access & pwrite & hit;
    assign rd_acc = access & ~pwrite & hit;
    assign region = paddr[7:6];
    assign chan   = paddr[5:4];
    assign sub    = paddr[3:2];
    assign misc   = paddr[5:2];

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    reg [NCH-1:0]    tx_command_reg;
    reg [CW*NCH-1:0] tx_control_reg;
    reg [CW*NCH-1:0] rx_control_reg;
    reg [2*NCH-1:0]  int_status_reg;
    reg [2*NCH-1:0]  int_mask_reg;
    reg [2*NCH-1:0]  fifo_warning_reg;

    // ----------------------------------------
    // FIFO channels
    // ----------------------------------------
    wire [CW*NCH-1:0] tx_occupancy;
    wire [CW*NCH-1:0] tx_free_bytes;
    wire [8*NCH-1:0]  tx_head;
    wire [NCH-1:0]    tx_empty;
    wire [NCH-1:0]    tx_full;
    wire [NCH-1:0]    tx_fw_wr;
    wire [NCH-1:0]    tx_pop;
    wire [NCH-1:0]    tx_underrun;
    wire [NCH-1:0]    tx_warn;
    wire [CW*NCH-1:0] rx_unread_bytes;
    wire [CW*NCH-1:0] rx_space_left;
    wire [8*NCH-1:0]  rx_head;
    wire [NCH-1:0]    rx_empty;
    wire [NCH-1:0]    rx_full;
    wire [NCH-1:0]    rx_fw_rd;
    wire [NCH-1:0]    rx_overrun;
    wire [NCH-1:0]    rx_warn;

    genvar i;
    generate
        for (i = 0; i < NCH; i = i + 1)
        begin : g_ch
            // Transmit channel i serves endpoint 2*i+1
            assign tx_fw_wr[i] = wr_acc && (region == `REGION_TX) &&
                                 (chan == i) && (sub == `OFS_DATA);  // see R6
            assign tx_pop[i]   = ep_tx_rd[i] & ~tx_empty[i];  // see R4
            // A read past the end of a final chunk is not an error
            assign tx_underrun[i] = ep_tx_rd[i] & tx_empty[i] &
                                    ~tx_command_reg[i];  // see R5
            assign tx_free_bytes[CW*i +: CW] = DEPTH_C - tx_occupancy[CW*i +: CW];  // see R9
            assign tx_warn[i] = (tx_occupancy[CW*i +: CW] <=
                                 tx_control_reg[CW*i +: CW]);  // see R8

            stream_byte_fifo #(
                .DEPTH (DEPTH),
                .AW    (AW),
                .CW    (CW)
            ) u_tx (
                .pclk    (pclk),
                .presetn (presetn),
                .ce      (ce),
                .wr_en   (tx_fw_wr[i]),
                .wr_data (pwdata[7:0]),
                .rd_en   (tx_pop[i]),
                .rd_data (tx_head[8*i +: 8]),
                .count   (tx_occupancy[CW*i +: CW]),
                .full    (tx_full[i]),
                .empty   (tx_empty[i])
            );  // see R1

            // Receive channel i serves endpoint 2*i+2
            assign rx_fw_rd[i] = rd_acc && (region == `REGION_RX) &&
                                 (chan == i) && (sub == `OFS_DATA);  // see R12
            // Dropped byte on overrun; stored data stays intact
            assign rx_overrun[i] = ep_rx_wr[i] & rx_full[i];  // see R15
            assign rx_space_left[CW*i +: CW] = DEPTH_C - rx_unread_bytes[CW*i +: CW];  // see R16
            assign rx_warn[i] = (rx_space_left[CW*i +: CW] <=
                                 rx_control_reg[CW*i +: CW]);  // see R16

            stream_byte_fifo #(
                .DEPTH (DEPTH),
                .AW    (AW),
                .CW    (CW)
            ) u_rx (
                .pclk    (pclk),
                .presetn (presetn),
                .ce      (ce),
                .wr_en   (ep_rx_wr[i]),
                .wr_data (ep_rx_wdata[8*i +: 8]),
                .rd_en   (rx_fw_rd[i]),
                .rd_data (rx_head[8*i +: 8]),
                .count   (rx_unread_bytes[CW*i +: CW]),
                .full    (rx_full[i]),
                .empty   (rx_empty[i])
            );  // see R10 see R14
        end
    endgenerate

    // ----------------------------------------
    // Read data mux
    // ----------------------------------------
    reg [31:0] rdata_next;

    always @*
    begin
        rdata_next = 32'h0000_0000;
        if (!hit)
        begin
            rdata_next = 32'h0000_0000;
        end
        else if (region == `REGION_TX)
        begin
            if (sub == `OFS_CMD)
            begin
                rdata_next[`CMD_LAST_BIT] = tx_command_reg[chan];
            end
            else if (sub == `OFS_CTRL)
            begin
                rdata_next[CW-1:0] = tx_control_reg[CW*chan +: CW];
            end
            else if (sub == `OFS_STAT)
            begin
                rdata_next[CW-1:0] = tx_free_bytes[CW*chan +: CW];  // see R9
            end
        end
        else if (region == `REGION_RX)
        begin
            if (sub == `OFS_DATA)
            begin
                rdata_next[7:0] = rx_head[8*chan +: 8];  // see R13
            end
            else if (sub == `OFS_CTRL)
            begin
                rdata_next[CW-1:0] = rx_control_reg[CW*chan +: CW];
            end
            else if (sub == `OFS_STAT)
            begin
                rdata_next[CW-1:0] = rx_unread_bytes[CW*chan +: CW];  // see R17
            end
        end
        else if (misc == `MISC_WARN)
        begin
            rdata_next[2*NCH-1:0] = fifo_warning_reg;
        end
        else if (misc == `MISC_ISTAT)
        begin
            rdata_next[2*NCH-1:0] = int_status_reg;
        end
        else if (misc == `MISC_IMASK)
        begin
            rdata_next[2*NCH-1:0] = int_mask_reg;
        end
    end

    // ----------------------------------------
    // APB response
    // ----------------------------------------
    // Data is sampled in the setup cycle; the pop waits for completion
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else if (ce)
        begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped(paddr);
            if (psel && !penable && !pwrite)
            begin
                prdata <= rdata_next;
            end
        end
    end

    // ----------------------------------------
    // Register writes and events
    // ----------------------------------------
    wire [2*NCH-1:0] events;
    wire [2*NCH-1:0] w1c;
    wire             misc_wr;
    integer          k;

    assign events  = {rx_overrun, tx_underrun};
    assign misc_wr = wr_acc && (region == `REGION_MISC);
    assign w1c     = (misc_wr && misc == `MISC_ISTAT) ? pwdata[2*NCH-1:0] : {2*NCH{1'b0}};

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_command_reg   <= {NCH{1'b0}};
            tx_control_reg   <= {NCH{`THR_RESET}};
            rx_control_reg   <= {NCH{`THR_RESET}};
            int_status_reg   <= {2*NCH{1'b0}};
            int_mask_reg     <= `IMASK_RESET;
            fifo_warning_reg <= {2*NCH{1'b0}};
        end
        else if (ce)
        begin
            for (k = 0; k < NCH; k = k + 1)
            begin
                if (wr_acc && region == `REGION_TX && chan == k && sub == `OFS_CMD)
                begin
                    tx_command_reg[k] <= pwdata[`CMD_LAST_BIT];
                end
                if (wr_acc && region == `REGION_TX && chan == k && sub == `OFS_CTRL)
                begin
                    tx_control_reg[CW*k +: CW] <= pwdata[CW-1:0];
                end
                if (wr_acc && region == `REGION_RX && chan == k && sub == `OFS_CTRL)
                begin
                    rx_control_reg[CW*k +: CW] <= pwdata[CW-1:0];
                end
            end
            if (misc_wr && misc == `MISC_IMASK)
            begin
                int_mask_reg <= pwdata[2*NCH-1:0];
            end
            // A new event outweighs a clear in the same cycle
            int_status_reg   <= (int_status_reg & ~w1c) | events;  // see R5 see R15
            fifo_warning_reg <= {rx_warn, tx_warn};  // see R8 see R16
        end
    end

    // ----------------------------------------
    // Endpoint side outputs
    // ----------------------------------------
    integer m;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ep_tx_data  <= {8*NCH{1'b0}};
            ep_tx_avail <= {NCH{1'b0}};
            ep_rx_space <= {NCH{1'b0}};
            irq         <= 1'b0;
        end
        else if (ce)
        begin
            for (m = 0; m < NCH; m = m + 1)
            begin
                if (tx_pop[m])
                begin
                    ep_tx_data[8*m +: 8] <= tx_head[8*m +: 8];  // see R3
                end
            end
            // Flags lag the FIFO by a cycle; callers must tolerate one extra
            ep_tx_avail <= ~tx_empty;
            ep_rx_space <= ~rx_full;
            irq         <= |(((int_status_reg & ~w1c) | events) & int_mask_reg);
        end
    end

endmodule

// [usb_endpoint_stream_fifos_checker.sv]
`timescale 1ns/1ps
module fifo_apb_checker #(
    parameter NCH = 3
) (
    // Clock and reset
    input wire             pclk,
    input wire             presetn,
    input wire             ce,
    // Register bus
    input wire             psel,
    input wire             penable,
    input wire             pwrite,
    input wire [7:0]       paddr,
    input wire             pready,
    input wire             pslverr,
    // Transmit side
    input wire [NCH-1:0]   ep_tx_rd,
    input wire [NCH-1:0]   ep_tx_avail,
    input wire [8*NCH-1:0] ep_tx_data
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // Bus steps
    // ----------------------------------------
    sequence s_setup;
        psel && !penable && ce;
    endsequence
    sequence s_unmapped;
        s_setup ##0 (paddr == 8'h44 || (paddr[7:6] != 2'h2 && paddr[5:4] == 2'h3));
    endsequence
    a_ready_next: assert property (s_setup |=> pready) else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready) else $error("ready held too long");
    a_ready_access: assert property (pready |-> psel && penable) else $error("ready outside access");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_err_unaligned: assert property (s_setup ##0 (paddr[1:0] != 2'h0) |=> pslverr)
        else $error("unaligned access accepted");
    a_err_unmapped: assert property (s_unmapped |=> pslverr) else $error("unmapped access accepted");
    a_mask_mapped: assert property (s_setup ##0 (paddr == 8'h88) |=> !pslverr)
        else $error("mask access refused");
    // Avail lags one cycle, so a write just before is excluded
    a_tx_empty_hold: assert property (ep_tx_rd[1] && !ep_tx_avail[1] && !$past(psel && pwrite)
        |=> $stable(ep_tx_data[15:8])) else $error("empty take changed data");
endmodule
bind usb_endpoint_stream_fifos fifo_apb_checker #(.NCH(NCH)) u_fifo_apb_checker (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .ep_tx_rd(ep_tx_rd),
    .ep_tx_avail(ep_tx_avail), .ep_tx_data(ep_tx_data));

// [ep_ctrl_model.sv]
`timescale 1ns/1ps
module ep_ctrl_model (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // Requests from the bench
    input  wire [2:0]  take_req,
    input  wire [2:0]  store_req,
    input  wire [7:0]  store_byte,
    // Endpoint controller pins
    output reg  [2:0]  ep_tx_rd,
    output reg  [2:0]  ep_rx_wr,
    output reg  [23:0] ep_rx_wdata
);
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ep_tx_rd <= 3'h0;
            ep_rx_wr <= 3'h0;
            ep_rx_wdata <= 24'h0;
        end
        else
        begin
            ep_tx_rd <= take_req;
            ep_rx_wr <= store_req;
            // Stale data is inverted so it never passes for valid
            ep_rx_wdata <= (|store_req) ? {3{store_byte}} : ~ep_rx_wdata;
        end
    end
endmodule

// [tb_usb_endpoint_stream_fifos.sv]
`timescale 1ns/1ps
module tb_usb_endpoint_stream_fifos;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [7:0]  paddr, sbyte;
    logic [31:0] pwdata, prdata, q;
    logic [2:0]  ep_tx_rd, ep_tx_avail, ep_rx_wr, ep_rx_space, take_req, store_req;
    logic [23:0] ep_tx_data, ep_rx_wdata;
    integer      num_errors, n_compared, i, c;

    usb_endpoint_stream_fifos u_usb_endpoint_stream_fifos (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ep_tx_rd(ep_tx_rd), .ep_tx_data(ep_tx_data),
        .ep_tx_avail(ep_tx_avail), .ep_rx_wr(ep_rx_wr), .ep_rx_wdata(ep_rx_wdata),
        .ep_rx_space(ep_rx_space), .irq(irq));
    ep_ctrl_model u_ep_ctrl_model (
        .pclk(pclk), .presetn(presetn), .take_req(take_req), .store_req(store_req),
        .store_byte(sbyte), .ep_tx_rd(ep_tx_rd), .ep_rx_wr(ep_rx_wr), .ep_rx_wdata(ep_rx_wdata));

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task tally_and_finish;
        if (num_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp)
        begin
            num_errors = num_errors + 1;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Master waits for ready, never assumes the latency
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        integer n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n = n + 1;
        end
        if (n == 20)
            num_errors = num_errors + 1;
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, q, exp);
    endtask
    task take(input integer ch);
        @(posedge pclk);
        take_req[ch] <= 1'b1;
        @(posedge pclk);
        take_req <= 3'h0;
        repeat (2) @(posedge pclk);
        #1;
    endtask
    task store(input integer ch, input logic [7:0] b);
        @(posedge pclk);
        store_req[ch] <= 1'b1;
        sbyte <= b;
        @(posedge pclk);
        store_req <= 3'h0;
        repeat (2) @(posedge pclk);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        rdchk(8'h08, 32'h8, "tx threshold");
        rdchk(8'h0c, 32'd64, "tx free");
        rdchk(8'h4c, 32'h0, "rx unread");
        rdchk(8'h88, 32'h0, "mask");
        rdchk(8'h80, 32'h7, "warn");
        apb(1'b0, 8'h44, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
        apb(1'b0, 8'h30, 32'h0);
        chk("channel 3", {31'h0, err}, 32'h1);
        apb(1'b0, 8'h0e, 32'h0);
        chk("unaligned", {31'h0, err}, 32'h1);
        apb(1'b1, 8'h28, 32'h3f);
        apb(1'b1, 8'h58, 32'd64);
        rdchk(8'h28, 32'h3f, "tx thr write");
        rdchk(8'h80, 32'h17, "warn thr");
        apb(1'b1, 8'h28, 32'h8);
        apb(1'b1, 8'h58, 32'h8);
    endtask
    task t_chans;
        for (c = 0; c < 3; c = c + 1)
        begin
            apb(1'b1, 8'(16 * c), 32'(8'h50 + c));
            take(c);
            chk("tx byte", {24'h0, ep_tx_data[8*c+:8]}, 32'(8'h50 + c));
            store(c, 8'(8'h60 + c));
            rdchk(8'(8'h40 + 16 * c), 32'(8'h60 + c), "rx byte");
        end
    endtask
    task t_tx;
        for (i = 0; i < 65; i = i + 1)
            apb(1'b1, 8'h10, 32'(i));
        rdchk(8'h1c, 32'h0, "tx full free");
        chk("tx avail full", {31'h0, ep_tx_avail[1]}, 32'h1);
        rdchk(8'h80, 32'h5, "warn full");
        for (i = 0; i < 64; i = i + 1)
        begin
            take(1);
            chk("tx order", {24'h0, ep_tx_data[15:8]}, 32'(i));
            if (i == 54)
                rdchk(8'h80, 32'h5, "warn nine");
            if (i == 55)
                rdchk(8'h80, 32'h7, "warn eight");
        end
        rdchk(8'h1c, 32'd64, "tx empty free");
        chk("tx avail empty", {31'h0, ep_tx_avail[1]}, 32'h0);
        take(1);
        chk("underrun hold", {24'h0, ep_tx_data[15:8]}, 32'd63);
        rdchk(8'h84, 32'h2, "underrun");
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, 8'h88, 32'h2);
        repeat (2) @(posedge pclk);
        chk("irq on", {31'h0, irq}, 32'h1);
        apb(1'b1, 8'h84, 32'h2);
        repeat (2) @(posedge pclk);
        chk("irq off", {31'h0, irq}, 32'h0);
        apb(1'b1, 8'h14, 32'h1);
        rdchk(8'h14, 32'h1, "last bit");
        take(1);
        rdchk(8'h84, 32'h0, "last set");
        apb(1'b1, 8'h14, 32'h0);
        apb(1'b1, 8'h88, 32'h0);
    endtask
    task t_rx;
        for (i = 0; i < 65; i = i + 1)
        begin
            store(0, 8'(i) ^ 8'h3c);
            if (i == 54)
                rdchk(8'h80, 32'h7, "rx warn nine");
            if (i == 55)
                rdchk(8'h80, 32'hf, "rx warn eight");
        end
        rdchk(8'h4c, 32'd64, "rx unread full");
        chk("rx space full", {31'h0, ep_rx_space[0]}, 32'h0);
        rdchk(8'h84, 32'h8, "overrun");
        apb(1'b1, 8'h84, 32'h8);
        for (i = 0; i < 64; i = i + 1)
            rdchk(8'h40, 32'(8'(i) ^ 8'h3c), "rx order");
        rdchk(8'h40, 32'h03, "rx repeat");
        rdchk(8'h4c, 32'h0, "rx empty");
        chk("rx space free", {31'h0, ep_rx_space[0]}, 32'h1);
        rdchk(8'h84, 32'h0, "no event");
    endtask
    // Enable low must swallow a store pulse
    task t_freeze;
        @(posedge pclk);
        ce <= 1'b0;
        store(2, 8'h77);
        ce <= 1'b1;
        rdchk(8'h6c, 32'h0, "frozen store");
    endtask

    initial
    begin
        num_errors = 0;
        n_compared = 0;
        presetn = 1'b0;
        ce = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, take_req, store_req, sbyte} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_chans;
        t_tx;
        t_rx;
        t_freeze;
        tally_and_finish;
    end
    // Whole run is near 1100 cycles
    initial
    begin
        #100000;
        num_errors = num_errors + 1;
        tally_and_finish;
    end
endmodule
